// File: core/e1cid_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef E1CID_DEFS_SVH
`define E1CID_DEFS_SVH

// identification and factory test registers
`define E1CID_ADDR_IDR         8'h0f
`define E1CID_ADDR_TEST_A      8'h09
`define E1CID_ADDR_TEST_B      8'h15
`define E1CID_ADDR_TEST_C      8'h19
`define E1CID_ADDR_TEST_MON    8'hac
// control registers
`define E1CID_ADDR_RCR_ONE     8'h10
`define E1CID_ADDR_RCR_TWO     8'h11
`define E1CID_ADDR_TCR_ONE     8'h12
`define E1CID_ADDR_TCR_TWO     8'h13
`define E1CID_ADDR_CCR_ONE     8'h14
`define E1CID_ADDR_CCR_TWO     8'h1a
`define E1CID_ADDR_CCR_THREE   8'h1b
`define E1CID_ADDR_CCR_FOUR    8'ha8
`define E1CID_ADDR_CCR_FIVE    8'haa
`define E1CID_ADDR_CCR_SIX     8'h1d
// link and interleave registers at the top of the map
`define E1CID_ADDR_IBO         8'hb5
`define E1CID_ADDR_TX_INFO     8'hb6
`define E1CID_ADDR_TX_FIFO     8'hb7
`define E1CID_ADDR_RX_CH_A     8'hb8
`define E1CID_ADDR_RX_CH_B     8'hb9
`define E1CID_ADDR_TX_CH_A     8'hba
`define E1CID_ADDR_TX_CH_B     8'hbb
`define E1CID_ADDR_UNUSED_LO   8'hbc
`define E1CID_ADDR_UNUSED_HI   8'hbf
// banks from here upward are not reachable
`define E1CID_ADDR_BLOCKED     8'hc0
`define E1CID_STORE_DEPTH      192
// field positions and values
`define E1CID_LI_RESET_BIT     7
`define E1CID_ESR_TX_BIT       0
`define E1CID_ESR_RX_BIT       1
`define E1CID_IDR_FAMILY_E1    1'b1
`define E1CID_MON_MASK         8'h0f
`define E1CID_BYTE_RESET       8'h00
// line interface recovery time
`define E1CID_CLK_HZ           25000000
`define E1CID_LI_RECOVER_MS    40
`define E1CID_LI_RECOVER_CYC   ((`E1CID_LI_RECOVER_MS * `E1CID_CLK_HZ) / 1000)
`define E1CID_LI_CNT_W         20

`endif

// File: core/e1cid_pkg.sv
// types shared by the configuration and identification block
`default_nettype none
`include "e1cid_defs.svh"

package e1cid_pkg;
	typedef logic [7:0] e1cid_byte_t;
	typedef logic [7:0] e1cid_addr_t;

	typedef enum logic {
		E1CID_LI_IDLE    = 1'b0,
		E1CID_LI_RECOVER = 1'b1
	} e1cid_li_state_t;

	typedef struct packed {
		logic [`E1CID_STORE_DEPTH-1:0][7:0] mem;
		e1cid_byte_t                        rdata;
		logic                               rvalid;
		logic                               li_rise;
		logic [1:0]                         es_rise;
		e1cid_byte_t                        mon_sel;
		logic                               test_clear;
	} e1cid_regs_state_t;

	typedef struct packed {
		e1cid_li_state_t            state;
		logic [`E1CID_LI_CNT_W-1:0] cnt;
		logic                       li_reset;
		logic                       li_busy;
		logic                       es_tx;
		logic                       es_rx;
	} e1cid_seq_state_t;
endpackage

`default_nettype wire

// File: core/e1cid_seq_if.sv
// reset request and reset pulse signals between register file and sequencer
`default_nettype none

interface e1cid_seq_if;
	logic       li_rise;
	logic [1:0] es_rise;
	logic       tx_stable;
	logic       rx_stable;
	logic       li_reset;
	logic       li_busy;
	logic       es_tx_reset;
	logic       es_rx_reset;

	modport regs (output li_rise, es_rise, tx_stable, rx_stable,
		input li_reset, li_busy, es_tx_reset, es_rx_reset);
	modport seq (input li_rise, es_rise, tx_stable, rx_stable,
		output li_reset, li_busy, es_tx_reset, es_rx_reset);
endinterface

`default_nettype wire

// File: core/e1cid_reset_seq.sv
// line interface and elastic store reset sequencer
`default_nettype none
`include "e1cid_defs.svh"

module e1cid_reset_seq #(
	parameter int unsigned LI_CYC = `E1CID_LI_RECOVER_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	e1cid_seq_if.seq  sq
);
	import e1cid_pkg::*;

	e1cid_seq_state_t st_reg;
	e1cid_seq_state_t st_next;

	// a new rising write restarts recovery even while one is running
	always_comb begin
		st_next          = st_reg;
		st_next.li_reset = sq.li_rise;
		// stores are only reset once both system clocks are stable
		st_next.es_tx    = sq.es_rise[0] & sq.tx_stable & sq.rx_stable;
		st_next.es_rx    = sq.es_rise[1] & sq.tx_stable & sq.rx_stable;
		unique case (st_reg.state)
			E1CID_LI_IDLE: begin
				if (sq.li_rise) begin
					st_next.state = E1CID_LI_RECOVER;
					st_next.cnt   = `E1CID_LI_CNT_W'(LI_CYC - 1);
				end
			end
			E1CID_LI_RECOVER: begin
				if (sq.li_rise) begin
					st_next.cnt = `E1CID_LI_CNT_W'(LI_CYC - 1);
				end else if (st_reg.cnt == '0) begin
					st_next.state = E1CID_LI_IDLE;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
		endcase
		st_next.li_busy = (st_next.state == E1CID_LI_RECOVER);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sq.li_reset    = st_reg.li_reset;
	assign sq.li_busy     = st_reg.li_busy;
	assign sq.es_tx_reset = st_reg.es_tx;
	assign sq.es_rx_reset = st_reg.es_rx;
endmodule

`default_nettype wire

// File: core/e1cid_regs.sv
// configuration, identification and test register bank of the transceiver
`default_nettype none
`include "e1cid_defs.svh"

// Function
// - addresses c0h to ffh are unreachable, writes dropped and reads zero.
// - ten control registers exist, two receive, two transmit, six common.
// - identification register at 0fh is read only and its top bit is one.
// - identification bits 6 to 4 carry the fixed family member code.
// - identification bits 3 to 0 carry the decimal die revision.
// - factory test registers sit at 09h, 15h, 19h and ach.
// - chosen bits of the test register at ach select monitor functions.
// - a zero to one write of the line reset bit resets the line for 40 ms.
// - elastic store reset bits reset the stores once system clocks are stable.
// - b5h to bbh read and write, bch to bfh are unused and set to zero; here bch to bfh store writes and read them back.
module e1cid_regs #(
	parameter logic [2:0]  DEVICE_CODE = 3'h1, // arbitrary value
	parameter logic [3:0]  REVISION    = 4'h0, // arbitrary value
	parameter int unsigned LI_CYC      = `E1CID_LI_RECOVER_CYC
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire e1cid_pkg::e1cid_addr_t addr_i,
	input  wire e1cid_pkg::e1cid_byte_t wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	input  wire logic                  tx_sysclk_stable_i,
	input  wire logic                  rx_sysclk_stable_i,
	output logic [7:0]                 rdata_o,
	output logic                       rvalid_o,
	output logic                       li_reset_o,
	output logic                       li_recovering_o,
	output logic                       es_tx_reset_o,
	output logic                       es_rx_reset_o,
	output logic [7:0]                 monitor_sel_o,
	output logic                       test_clear_o
);
	import e1cid_pkg::*;

	localparam e1cid_byte_t ID_VALUE =
		{`E1CID_IDR_FAMILY_E1, DEVICE_CODE, REVISION};

	e1cid_regs_state_t st_reg;
	e1cid_regs_state_t st_next;
	e1cid_seq_if       sq ();

	// address lies below the blocked banks
	function automatic logic is_mapped(input e1cid_addr_t a);
		return a < `E1CID_ADDR_BLOCKED;
	endfunction

	// address is one of the four factory test registers
	function automatic logic is_test(input e1cid_addr_t a);
		return (a == `E1CID_ADDR_TEST_A) || (a == `E1CID_ADDR_TEST_B) ||
			(a == `E1CID_ADDR_TEST_C) || (a == `E1CID_ADDR_TEST_MON);
	endfunction

	// storage index of a mapped address
	function automatic logic [7:0] slot(input e1cid_addr_t a);
		return a;
	endfunction

	// register file next state: write, read, and rising-bit detection
	always_comb begin
		st_next         = st_reg;
		st_next.rvalid  = 1'b0;
		st_next.li_rise = 1'b0;
		st_next.es_rise = 2'b00;
		// blocked banks and the id register never take a write
		if (wr_i && is_mapped(addr_i) &&
			addr_i != `E1CID_ADDR_IDR) begin
			// control, test and link registers all store here
			st_next.mem[slot(addr_i)] = wdata_i;
			if (addr_i == `E1CID_ADDR_CCR_FIVE) begin
				// only a zero to one change resets the line
				st_next.li_rise = wdata_i[`E1CID_LI_RESET_BIT] &
					~st_reg.mem[slot(addr_i)][`E1CID_LI_RESET_BIT];
			end
			if (addr_i == `E1CID_ADDR_CCR_SIX) begin
				st_next.es_rise[0] = wdata_i[`E1CID_ESR_TX_BIT] &
					~st_reg.mem[slot(addr_i)][`E1CID_ESR_TX_BIT];
				st_next.es_rise[1] = wdata_i[`E1CID_ESR_RX_BIT] &
					~st_reg.mem[slot(addr_i)][`E1CID_ESR_RX_BIT];
			end
		end
		// a read returns the value before any write of the same cycle
		if (rd_i) begin
			st_next.rvalid = 1'b1;
			if (!is_mapped(addr_i)) begin
				st_next.rdata = `E1CID_BYTE_RESET;
			end else if (addr_i == `E1CID_ADDR_IDR) begin
				st_next.rdata = ID_VALUE;
			end else begin
				st_next.rdata = st_reg.mem[slot(addr_i)];
			end
		end
		// only the monitor bits reach monitor_sel_o, the rest feed only the test_clear_o check and the read data
		st_next.mon_sel = st_next.mem[slot(`E1CID_ADDR_TEST_MON)] &
			`E1CID_MON_MASK;
		// shows whether the host has cleared the test registers
		st_next.test_clear =
			(st_next.mem[slot(`E1CID_ADDR_TEST_A)] == '0) &&
			(st_next.mem[slot(`E1CID_ADDR_TEST_B)] == '0) &&
			(st_next.mem[slot(`E1CID_ADDR_TEST_C)] == '0) &&
			(st_next.mem[slot(`E1CID_ADDR_TEST_MON)] == '0);
	end

	// contents are cleared at reset so nothing starts undefined
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// requests toward the sequencer leave from flops
	assign sq.li_rise   = st_reg.li_rise;
	assign sq.es_rise   = st_reg.es_rise;
	assign sq.tx_stable = tx_sysclk_stable_i;
	assign sq.rx_stable = rx_sysclk_stable_i;

	e1cid_reset_seq #(
		.LI_CYC (LI_CYC)
	) u_seq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.sq    (sq)
	);

	// outputs, each a flop here or in the sequencer
	assign rdata_o         = st_reg.rdata;
	assign rvalid_o        = st_reg.rvalid;
	assign monitor_sel_o   = st_reg.mon_sel;
	assign test_clear_o    = st_reg.test_clear;
	assign li_reset_o      = sq.li_reset;
	assign li_recovering_o = sq.li_busy;
	assign es_tx_reset_o   = sq.es_tx_reset;
	assign es_rx_reset_o   = sq.es_rx_reset;

	// checks on the bank behaviour
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_li_rise_write;
		wr_i && addr_i == `E1CID_ADDR_CCR_FIVE &&
		wdata_i[`E1CID_LI_RESET_BIT] &&
		!st_reg.mem[slot(`E1CID_ADDR_CCR_FIVE)][`E1CID_LI_RESET_BIT];
	endsequence

	a_blocked_read_zero: assert property (
		rd_i && !is_mapped(addr_i) |=> rvalid_o && rdata_o == 8'h00)
		else $error("blocked bank read did not return zero");

	a_blocked_no_store: assert property (
		wr_i && !is_mapped(addr_i) |=> $stable(st_reg.mem))
		else $error("write to blocked bank changed storage");

	a_id_family_e1: assert property (
		rd_i && addr_i == `E1CID_ADDR_IDR |=> rdata_o[7] == 1'b1)
		else $error("id register top bit not one");

	a_id_member_code: assert property (
		rd_i && addr_i == `E1CID_ADDR_IDR |=> rdata_o[6:4] == DEVICE_CODE)
		else $error("id register member code wrong");

	a_id_revision: assert property (
		rd_i && addr_i == `E1CID_ADDR_IDR |=> rdata_o[3:0] == REVISION)
		else $error("id register revision wrong");

	a_id_write_ignored: assert property (
		wr_i && addr_i == `E1CID_ADDR_IDR ##1
		rd_i && addr_i == `E1CID_ADDR_IDR |=> rdata_o == ID_VALUE)
		else $error("id register changed by a write");

	a_test_dirty_seen: assert property (
		wr_i && addr_i == `E1CID_ADDR_TEST_B && wdata_i != 8'h00
		|=> !test_clear_o)
		else $error("nonzero test register not reported");

	a_monitor_select: assert property (
		wr_i && addr_i == `E1CID_ADDR_TEST_MON
		|=> monitor_sel_o == ($past(wdata_i) & `E1CID_MON_MASK))
		else $error("monitor select does not follow test register");

	a_link_readback: assert property (
		wr_i && addr_i == `E1CID_ADDR_IBO ##1
		(rd_i && !wr_i && addr_i == `E1CID_ADDR_IBO)
		|=> rvalid_o && rdata_o == $past(wdata_i, 2))
		else $error("interleave register did not read back");

	a_li_reset_pulse: assert property (
		s_li_rise_write |-> ##2 li_reset_o && li_recovering_o
		##1 !li_reset_o && li_recovering_o)
		else $error("line reset pulse or recovery missing");

	a_li_no_spurious: assert property (
		li_reset_o |-> $past(st_reg.li_rise))
		else $error("line reset without a rising write");

	a_es_gated: assert property (
		es_tx_reset_o || es_rx_reset_o
		|-> $past(tx_sysclk_stable_i) && $past(rx_sysclk_stable_i))
		else $error("store reset while system clocks unstable");

	a_es_tx_follows: assert property (
		wr_i && addr_i == `E1CID_ADDR_CCR_SIX &&
		wdata_i[`E1CID_ESR_TX_BIT] &&
		!st_reg.mem[slot(`E1CID_ADDR_CCR_SIX)][`E1CID_ESR_TX_BIT]
		##1 tx_sysclk_stable_i && rx_sysclk_stable_i
		|=> es_tx_reset_o ##1 !es_tx_reset_o)
		else $error("transmit store reset pulse missing");

	// cycles spent in line recovery, counted from the reset pulse
	// kept apart from the bank state since only the checks read it
	int unsigned rec_cnt;

	// restarts on every reset pulse so a rewrite stretches the window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rec_cnt <= 0;
		end else if (!li_recovering_o) begin
			rec_cnt <= 0;
		end else if (li_reset_o) begin
			rec_cnt <= 1;
		end else begin
			rec_cnt <= rec_cnt + 1;
		end
	end

	a_li_recover_len: assert property (
		$fell(li_recovering_o) |-> rec_cnt == LI_CYC)
		else $error("line recovery did not last its full time");

	a_li_recover_bound: assert property (
		rec_cnt <= LI_CYC)
		else $error("line recovery ran past its full time");

	a_li_single_pulse: assert property (
		li_reset_o |=> !li_reset_o)
		else $error("line reset pulse longer than one cycle");

	a_rvalid_from_read: assert property (
		rvalid_o |-> $past(rd_i))
		else $error("read data marked valid without a read");

	a_read_answered: assert property (
		rd_i |=> rvalid_o)
		else $error("read not answered the next cycle");

	a_ctrl_readback: assert property (
		wr_i && addr_i == `E1CID_ADDR_RCR_ONE ##1
		(rd_i && !wr_i && addr_i == `E1CID_ADDR_RCR_ONE)
		|=> rdata_o == $past(wdata_i, 2))
		else $error("control register did not read back");

	a_test_readback: assert property (
		wr_i && addr_i == `E1CID_ADDR_TEST_MON ##1
		(rd_i && !wr_i && addr_i == `E1CID_ADDR_TEST_MON)
		|=> rdata_o == $past(wdata_i, 2))
		else $error("test register did not read back");

	a_test_a_dirty: assert property (
		wr_i && addr_i == `E1CID_ADDR_TEST_A && wdata_i != 8'h00
		|=> !test_clear_o)
		else $error("nonzero first test register not reported");

	a_mon_upper_zero: assert property (
		monitor_sel_o[7:4] == 4'h0)
		else $error("monitor select shows bits outside its mask");

	a_es_rx_follows: assert property (
		wr_i && addr_i == `E1CID_ADDR_CCR_SIX &&
		wdata_i[`E1CID_ESR_RX_BIT] &&
		!st_reg.mem[slot(`E1CID_ADDR_CCR_SIX)][`E1CID_ESR_RX_BIT]
		##1 tx_sysclk_stable_i && rx_sysclk_stable_i
		|=> es_rx_reset_o ##1 !es_rx_reset_o)
		else $error("receive store reset pulse missing");

	a_es_tx_origin: assert property (
		es_tx_reset_o |-> $past(st_reg.es_rise[0]))
		else $error("transmit store reset without a rising write");

	a_es_rx_origin: assert property (
		es_rx_reset_o |-> $past(st_reg.es_rise[1]))
		else $error("receive store reset without a rising write");

	c_li_reset: cover property (s_li_rise_write ##2 li_reset_o);
	c_es_reset: cover property (es_tx_reset_o && es_rx_reset_o);
	c_id_read: cover property (rd_i && addr_i == `E1CID_ADDR_IDR);
	c_blocked_read: cover property (rd_i && !is_mapped(addr_i));
endmodule

`default_nettype wire

// File: dv/e1cid_host.sv
// host processor model driving the parallel control port
`default_nettype none

module e1cid_host (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic            tx_st_o,
	output logic            rx_st_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus, system clocks not yet stable
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		tx_st_o = 1'b0;
		rx_st_o = 1'b0;
	end

	// released lines show inverted leftovers, never the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// read valid stands for one cycle only, so take it at the next fall
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
		v = rvalid_i;
	endtask

	// write then read the same register in the very next cycle
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw,
		output logic [7:0] d, output logic v);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = dw;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~dw;
		d = rdata_i;
		v = rvalid_i;
	endtask

	// store resets only make sense once both clocks are steady
	task automatic set_clk(input logic tx, input logic rx);
		@(negedge clk_i);
		tx_st_o = tx;
		rx_st_o = rx;
	endtask

	// power-up: clear every factory test register; stores stay off
	// so the store reset step is left out here
	task automatic init();
		wr(8'h09, 8'h00);
		wr(8'h15, 8'h00);
		wr(8'h19, 8'h00);
		wr(8'hac, 8'h00);
	endtask
endmodule

`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the configuration and identification bank
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LI = 20;
	localparam logic [7:0] RW [15] = '{8'hb5, 8'hb6, 8'hb7, 8'hb8,
		8'hb9, 8'hba, 8'hbb, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
		8'h1a, 8'h1b, 8'ha8};
	logic       clk;
	logic       rst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       tx_st;
	logic       rx_st;
	logic [7:0] rdata;
	logic       rvalid;
	logic       li_rst;
	logic       li_rec;
	logic       es_tx;
	logic       es_rx;
	logic [7:0] mon;
	logic       tclr;
	int         n_mismatch = 0;
	int         checks_done = 0;
	int         cycles = 0;

	e1cid_host i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.tx_st_o(tx_st), .rx_st_o(rx_st));

	e1cid_regs #(.DEVICE_CODE(3'h5), .REVISION(4'h9), .LI_CYC(LI)) i_dut (
		.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .tx_sysclk_stable_i(tx_st),
		.rx_sysclk_stable_i(rx_st), .rdata_o(rdata), .rvalid_o(rvalid),
		.li_reset_o(li_rst), .li_recovering_o(li_rec),
		.es_tx_reset_o(es_tx), .es_rx_reset_o(es_rx),
		.monitor_sel_o(mon), .test_clear_o(tclr));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		i_host.rd(a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask

	// write immediately followed by a read of the same address
	task automatic wrchk(input logic [7:0] a, input logic [7:0] dw,
		input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		i_host.wr_rd(a, dw, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask

	task automatic t_ident();
		rchk(8'h0f, {1'b1, 3'h5, 4'h9});
		i_host.wr(8'h0f, 8'h00);
		rchk(8'h0f, {1'b1, 3'h5, 4'h9});
	endtask

	task automatic t_test();
		i_host.wr(8'h19, 8'h5a);
		@(negedge clk);
		chk({7'h00, tclr}, 8'h00);
		i_host.wr(8'hac, 8'hf5);
		@(negedge clk);
		chk(mon, 8'h05);
		rchk(8'hac, 8'hf5);
		rchk(8'h19, 8'h5a);
		i_host.init();
		@(negedge clk);
		chk({7'h00, tclr}, 8'h01);
		chk(mon, 8'h00);
	endtask

	// one address in each blocked bank
	task automatic t_block();
		for (int i = 0; i < 4; i++) begin
			i_host.wr(8'(8'hc0 + i * 17), 8'ha5);
			rchk(8'(8'hc0 + i * 17), 8'h00);
		end
	endtask

	// all writes first, so aliased locations show up on readback
	task automatic t_rw();
		foreach (RW[i]) i_host.wr(RW[i], ~RW[i]);
		foreach (RW[i]) rchk(RW[i], ~RW[i]);
		i_host.wr(8'hbf, 8'h00);
		rchk(8'hbf, 8'h00);
		wrchk(8'hb5, 8'h3c, 8'h3c);
		wrchk(8'h10, 8'hc3, 8'hc3);
		wrchk(8'hac, 8'h0a, 8'h0a);
		wrchk(8'h0f, 8'hff, {1'b1, 3'h5, 4'h9});
	endtask

	// rising write of the line reset bit, pulse two cycles later
	task automatic li_go();
		i_host.wr(8'haa, 8'h00);
		i_host.wr(8'haa, 8'h80);
		chk({7'h00, li_rst}, 8'h00);
		@(negedge clk);
		chk({li_rst, li_rec}, 8'h03);
	endtask

	task automatic li_len();
		int n;
		n = 0;
		while (li_rec === 1'b1 && n < 100) begin
			n++;
			@(negedge clk);
		end
		chk(8'(n), 8'(LI));
	endtask

	task automatic t_line();
		li_go();
		li_len();
		i_host.wr(8'haa, 8'h80);
		repeat (2) @(negedge clk);
		chk({li_rst, li_rec}, 8'h00);
		li_go();
		repeat (5) @(negedge clk);
		li_go();
		li_len();
	endtask

	task automatic es_try(input logic [7:0] d, input logic [1:0] e);
		i_host.wr(8'h1d, 8'h00);
		i_host.wr(8'h1d, d);
		chk({es_tx, es_rx}, 8'h00);
		@(negedge clk);
		chk({es_tx, es_rx}, {6'h00, e});
	endtask

	task automatic t_store();
		i_host.set_clk(1'b0, 1'b1);
		es_try(8'h03, 2'b00);
		i_host.set_clk(1'b1, 1'b0);
		es_try(8'h03, 2'b00);
		i_host.set_clk(1'b1, 1'b1);
		es_try(8'h01, 2'b10);
		es_try(8'h02, 2'b01);
		es_try(8'h03, 2'b11);
	endtask

	// reset held for 16 cycles, then the scenarios in turn
	initial begin
		rst = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		chk({tclr, li_rec, mon[3:0]}, 8'h20);
		i_host.init();
		t_ident();
		t_test();
		t_block();
		t_rw();
		t_line();
		t_store();
		finish_test();
	end
endmodule

`default_nettype wire
